// >>> pkg/chgim_pkg.sv
// Constants and field layout of the charger interrupt mask block
package chgim_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [7:0] OFS_CHG_FLAG_A = 8'h20;
  localparam logic [7:0] OFS_CHG_FLAG_B = 8'h21;
  localparam logic [7:0] OFS_FAULT_FLAG = 8'h22;
  localparam logic [7:0] OFS_CHARGE_STATE_IRQ_BLOCK_A = 8'h23;
  localparam logic [7:0] OFS_CHARGE_STATE_IRQ_BLOCK_B = 8'h24;
  localparam logic [7:0] OFS_FAULT_MASK = 8'h25;

  // Values after reset
  localparam logic [7:0] RST_CHARGE_STATE_IRQ_BLOCK_A = 8'h00;
  localparam logic [7:0] RST_CHARGE_STATE_IRQ_BLOCK_B = 8'h00;
  localparam logic [7:0] RST_FAULT_MASK = 8'h00;
  localparam logic [7:0] RST_FLAG = 8'h00;

  // Writable bits of each mask register
  localparam logic [7:0] WMASK_CHARGE_STATE_IRQ_BLOCK_A = 8'hFF;
  localparam logic [7:0] WMASK_CHARGE_STATE_IRQ_BLOCK_B = 8'h09;
  localparam logic [7:0] WMASK_FAULT_MASK = 8'hF9;

  // Fields of the first charger register pair
  localparam int unsigned BIT_ADC_DONE = 6;
  localparam int unsigned BIT_THERMAL_REG = 5;
  localparam int unsigned BIT_MIN_SYSTEM = 4;
  localparam int unsigned BIT_INPUT_CURRENT = 3;
  localparam int unsigned BIT_INPUT_VOLTAGE = 2;
  localparam int unsigned BIT_CHARGE_TIMER = 1;
  localparam int unsigned BIT_WATCHDOG = 0;

  // Fields of the second charger register pair
  localparam int unsigned BIT_CHARGE_STATE = 3;
  localparam int unsigned BIT_INPUT_BUS = 0;

  // Fields of the fault register pair
  localparam int unsigned BIT_BUS_FAULT = 7;
  localparam int unsigned BIT_BAT_FAULT = 6;
  localparam int unsigned BIT_SYS_FAULT = 5;
  localparam int unsigned BIT_OTG_FAULT = 4;
  localparam int unsigned BIT_THERMAL_SHUT = 3;
  localparam int unsigned BIT_TEMP_ZONE = 0;

  // Status vector widths
  localparam int unsigned CHG_STAT_W = 3;
  localparam int unsigned BUS_STAT_W = 3;
  localparam int unsigned TS_ZONE_W = 3;

  // Layout of the raw event vector fed to the detector
  localparam int unsigned RAW_W = 21;
  localparam int unsigned RAW_CHG_A_LO = 0;
  localparam int unsigned RAW_CHG_STAT_LO = 7;
  localparam int unsigned RAW_BUS_STAT_LO = 10;
  localparam int unsigned RAW_FAULT_LO = 13;
  localparam int unsigned RAW_TS_LO = 18;
  // Bits reported on any change rather than on a rising edge
  localparam logic [20:0] RAW_ANY_EDGE = 21'h1C_1F90;

  // Interrupt pulse width
  localparam int unsigned MCLK_MHZ = 125;
  localparam int unsigned INT_PULSE_NS = 256;
  localparam int unsigned INT_PULSE_CYC = (INT_PULSE_NS * MCLK_MHZ + 999) / 1000;
  localparam int unsigned PULSE_CNT_W = 8;
  localparam logic [7:0] PULSE_LOAD = 8'(INT_PULSE_CYC);

endpackage : chgim_pkg

// >>> logic/chgim_event_detect.sv
// Synchroniser and edge detector for the raw charger event signals
`timescale 1ns/1ps
module chgim_event_detect #(
  parameter int unsigned WIDTH = 21,
  parameter logic [WIDTH-1:0] ANY_EDGE = '0
) (
  input wire logic mclk, // Core clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [WIDTH-1:0] raw_in, // Asynchronous event levels
  output logic [WIDTH-1:0] edge_q // One-cycle event pulses
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] edge_d;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= '0;
    end else begin
      prev_q <= sync_q;
    end
  end

  // Rising edge, or any change where selected
  always_comb begin
    edge_d = (sync_q & ~prev_q) | ((sync_q ^ prev_q) & ANY_EDGE);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      edge_q <= '0;
    end else begin
      edge_q <= edge_d;
    end
  end

endmodule // chgim_event_detect

// >>> logic/chgim_top.sv
// Charger event flags, interrupt masks and active-low interrupt pulse
`timescale 1ns/1ps
module chgim_top (
  input wire logic mclk, // Core clock, 125 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic reg_reset, // Register reset command pulse
  input wire logic [chgim_pkg::ADDR_W-1:0] reg_addr, // Register offset
  input wire logic [chgim_pkg::DATA_W-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [chgim_pkg::DATA_W-1:0] reg_rdata_q, // Read data, one cycle after strobe
  input wire logic adc_one_shot, // ADC in one-shot mode
  input wire logic adc_done, // Conversion complete level
  input wire logic die_thermal_regulation, // Thermal regulation active
  input wire logic min_system_regulation, // Minimum system regulation active
  input wire logic input_current_regulation, // Input, pin or OTG current loop active
  input wire logic input_voltage_regulation, // Input or OTG voltage loop active
  input wire logic charge_timer_expired, // Safety timer expired
  input wire logic watchdog_expired, // Serial watchdog expired
  input wire logic [chgim_pkg::CHG_STAT_W-1:0] charge_status, // Charge state code
  input wire logic [chgim_pkg::BUS_STAT_W-1:0] input_bus_status, // Input bus state code
  input wire logic bus_fault, // Bus overvoltage or sleep
  input wire logic bat_fault, // Battery overcurrent or overvoltage
  input wire logic sys_fault, // System fault
  input wire logic otg_fault, // OTG fault
  input wire logic thermal_shutdown, // Thermal shutdown
  input wire logic [chgim_pkg::TS_ZONE_W-1:0] temp_zone, // Temperature zone code
  output logic int_n_q // Interrupt pulse, active low
);
  import chgim_pkg::*;

  logic [RAW_W-1:0] raw_vec;
  logic [RAW_W-1:0] edge_vec;
  logic [7:0] ev_a;
  logic [7:0] ev_b;
  logic [7:0] ev_f;
  logic [7:0] mask_a_q;
  logic [7:0] mask_b_q;
  logic [7:0] mask_f_q;
  logic [7:0] flag_a_q;
  logic [7:0] flag_b_q;
  logic [7:0] flag_f_q;
  logic [7:0] rdata_d;
  logic fire;
  logic [PULSE_CNT_W-1:0] pulse_cnt_q;

  function automatic logic unmasked(input logic [7:0] ev, input logic [7:0] mask);
    unmasked = |(ev & ~mask);
  endfunction

  function automatic logic [7:0] next_flag(input logic [7:0] flag, input logic [7:0] ev,
                                           input logic clr);
    // Set wins over clear-on-read
    next_flag = (clr ? 8'h00 : flag) | ev;
  endfunction

  function automatic logic [7:0] next_mask(input logic [7:0] mask, input logic [7:0] wdata,
                                           input logic wr, input logic [7:0] wmask);
    next_mask = wr ? (wdata & wmask) : mask;
  endfunction

  // Order must follow the raw layout and the any-edge selection in the package
  assign raw_vec = {temp_zone, bus_fault, bat_fault, sys_fault, otg_fault, thermal_shutdown,
                    input_bus_status, charge_status,
                    adc_done, die_thermal_regulation, min_system_regulation,
                    input_current_regulation, input_voltage_regulation,
                    charge_timer_expired, watchdog_expired};

  chgim_event_detect #(
    .WIDTH(RAW_W),
    .ANY_EDGE(RAW_ANY_EDGE)
  ) u_detect (
    .mclk(mclk),
    .rst_n(rst_n),
    .raw_in(raw_vec),
    .edge_q(edge_vec)
  );

  // Flag set events
  always_comb begin
    ev_a = 8'h00;
    ev_a[BIT_ADC_DONE] = edge_vec[RAW_CHG_A_LO + 6] & adc_one_shot;
    ev_a[BIT_THERMAL_REG] = edge_vec[RAW_CHG_A_LO + 5];
    ev_a[BIT_MIN_SYSTEM] = edge_vec[RAW_CHG_A_LO + 4];
    ev_a[BIT_INPUT_CURRENT] = edge_vec[RAW_CHG_A_LO + 3];
    ev_a[BIT_INPUT_VOLTAGE] = edge_vec[RAW_CHG_A_LO + 2];
    ev_a[BIT_CHARGE_TIMER] = edge_vec[RAW_CHG_A_LO + 1];
    ev_a[BIT_WATCHDOG] = edge_vec[RAW_CHG_A_LO];
    ev_b = 8'h00;
    ev_b[BIT_CHARGE_STATE] = |edge_vec[RAW_CHG_STAT_LO +: CHG_STAT_W];
    ev_b[BIT_INPUT_BUS] = |edge_vec[RAW_BUS_STAT_LO +: BUS_STAT_W];
    ev_f = 8'h00;
    ev_f[BIT_THERMAL_SHUT] = edge_vec[RAW_FAULT_LO];
    ev_f[BIT_OTG_FAULT] = edge_vec[RAW_FAULT_LO + 1];
    ev_f[BIT_SYS_FAULT] = edge_vec[RAW_FAULT_LO + 2];
    ev_f[BIT_BAT_FAULT] = edge_vec[RAW_FAULT_LO + 3];
    ev_f[BIT_BUS_FAULT] = edge_vec[RAW_FAULT_LO + 4];
    ev_f[BIT_TEMP_ZONE] = |edge_vec[RAW_TS_LO +: TS_ZONE_W];
  end

  // Mask registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mask_a_q <= RST_CHARGE_STATE_IRQ_BLOCK_A;
      mask_b_q <= RST_CHARGE_STATE_IRQ_BLOCK_B;
      mask_f_q <= RST_FAULT_MASK;
    end else if (reg_reset) begin
      mask_a_q <= RST_CHARGE_STATE_IRQ_BLOCK_A;
      mask_b_q <= RST_CHARGE_STATE_IRQ_BLOCK_B;
      mask_f_q <= RST_FAULT_MASK;
    end else begin
      mask_a_q <= next_mask(mask_a_q, reg_wdata, reg_wr && reg_addr == OFS_CHARGE_STATE_IRQ_BLOCK_A,
                            WMASK_CHARGE_STATE_IRQ_BLOCK_A);
      mask_b_q <= next_mask(mask_b_q, reg_wdata, reg_wr && reg_addr == OFS_CHARGE_STATE_IRQ_BLOCK_B,
                            WMASK_CHARGE_STATE_IRQ_BLOCK_B);
      mask_f_q <= next_mask(mask_f_q, reg_wdata, reg_wr && reg_addr == OFS_FAULT_MASK,
                            WMASK_FAULT_MASK);
    end
  end

  // Flags set regardless of mask, cleared by reading
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_a_q <= RST_FLAG;
      flag_b_q <= RST_FLAG;
      flag_f_q <= RST_FLAG;
    end else begin
      flag_a_q <= next_flag(flag_a_q, ev_a, reg_rd && reg_addr == OFS_CHG_FLAG_A);
      flag_b_q <= next_flag(flag_b_q, ev_b, reg_rd && reg_addr == OFS_CHG_FLAG_B);
      flag_f_q <= next_flag(flag_f_q, ev_f, reg_rd && reg_addr == OFS_FAULT_FLAG);
    end
  end

  // Read multiplexer, unmapped offsets read zero
  always_comb begin
    case (reg_addr)
      OFS_CHG_FLAG_A: rdata_d = flag_a_q;
      OFS_CHG_FLAG_B: rdata_d = flag_b_q;
      OFS_FAULT_FLAG: rdata_d = flag_f_q;
      OFS_CHARGE_STATE_IRQ_BLOCK_A: rdata_d = mask_a_q;
      OFS_CHARGE_STATE_IRQ_BLOCK_B: rdata_d = mask_b_q & WMASK_CHARGE_STATE_IRQ_BLOCK_B;
      OFS_FAULT_MASK: rdata_d = mask_f_q & WMASK_FAULT_MASK;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_d;
    end
  end

  // Interrupt request from any unmasked event
  always_comb begin
    fire = unmasked(ev_a, mask_a_q) | unmasked(ev_b, mask_b_q) | unmasked(ev_f, mask_f_q);
  end

  // Fixed-width low pulse, restarted by a new event
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_cnt_q <= '0;
    end else if (fire) begin
      pulse_cnt_q <= PULSE_LOAD;
    end else if (pulse_cnt_q != '0) begin
      pulse_cnt_q <= pulse_cnt_q - 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_n_q <= 1'b1;
    end else begin
      int_n_q <= !(fire || pulse_cnt_q > 8'h01);
    end
  end

endmodule // chgim_top

// >>> dv/chgim_top_props.sv
// Concurrent checks on the ports of the charger interrupt mask block
`timescale 1ns/1ps
module chgim_props (
  input wire logic mclk, // Core clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic reg_reset, // Register reset command
  input wire logic [chgim_pkg::ADDR_W-1:0] reg_addr, // Register offset
  input wire logic [chgim_pkg::DATA_W-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [chgim_pkg::DATA_W-1:0] reg_rdata_q, // Read data
  input wire logic watchdog_expired, // Watchdog expiry level
  input wire logic int_n_q // Interrupt, active low
);
  import chgim_pkg::*;
  logic [7:0] low_cnt_q;
  logic wd_blk_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) low_cnt_q <= 8'h00;
    else if (int_n_q) low_cnt_q <= 8'h00;
    else if (low_cnt_q != 8'hFF) low_cnt_q <= low_cnt_q + 8'h01;
  end
  // Mirror of the watchdog mask bit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) wd_blk_q <= 1'b0;
    else if (reg_reset) wd_blk_q <= 1'b0;
    else if (reg_wr && reg_addr == OFS_CHARGE_STATE_IRQ_BLOCK_A) wd_blk_q <= reg_wdata[0];
  end
  sequence s_reset_then_read;
    reg_reset ##1 !reg_wr ##1 (reg_rd && !reg_wr && !reg_reset && reg_addr == OFS_CHARGE_STATE_IRQ_BLOCK_A);
  endsequence
  sequence s_write_then_read;
    (reg_wr && !reg_reset && reg_addr == OFS_CHARGE_STATE_IRQ_BLOCK_A) ##1 (!reg_wr && !reg_reset)
      ##1 (reg_rd && !reg_wr && !reg_reset && reg_addr == OFS_CHARGE_STATE_IRQ_BLOCK_A);
  endsequence
  a_pulse_min_len: assert property ($rose(int_n_q) |-> low_cnt_q >= PULSE_LOAD)
    else $error("interrupt pulse shorter than the set width");
  a_mask_b_rsvd: assert property (reg_rd && reg_addr == OFS_CHARGE_STATE_IRQ_BLOCK_B |=> (reg_rdata_q & 8'hF6) == 8'h00)
    else $error("reserved bits of second mask read nonzero");
  a_fault_rsvd: assert property (reg_rd && reg_addr == OFS_FAULT_MASK |=> reg_rdata_q[2:1] == 2'b00)
    else $error("reserved bits of fault mask read nonzero");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata_q))
    else $error("read data changed without a read");
  a_cmd_clears: assert property (s_reset_then_read |=> reg_rdata_q == 8'h00)
    else $error("mask not cleared by register reset");
  a_write_back: assert property (s_write_then_read |=> reg_rdata_q == $past(reg_wdata, 3))
    else $error("first mask register read back wrong");
  a_quiet_release: assert property ($rose(rst_n) |-> int_n_q [*3])
    else $error("interrupt low right after reset");
  a_wdog_pulse: assert property ($rose(watchdog_expired) && !wd_blk_q |-> ##[3:5] !int_n_q)
    else $error("no interrupt after unmasked watchdog expiry");
endmodule // chgim_props
bind chgim_top chgim_props u_props (.mclk(mclk), .rst_n(rst_n), .reg_reset(reg_reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .watchdog_expired(watchdog_expired), .int_n_q(int_n_q));

// >>> dv/chgim_host.sv
// Host side model that counts and times interrupt pulses
`timescale 1ns/1ps
module chgim_host (
  input wire logic mclk, // Core clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic int_n_q, // Interrupt line from the device
  output int irq_count, // Pulses seen
  output int last_width // Low cycles of the latest pulse
);
  int low_run;
  logic int_prev;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      low_run <= 0;
      int_prev <= 1'b1;
      irq_count <= 0;
      last_width <= 0;
    end else begin
      int_prev <= int_n_q;
      low_run <= int_n_q ? 0 : low_run + 1;
      if (int_prev && !int_n_q) irq_count <= irq_count + 1;
      if (!int_prev && int_n_q) last_width <= low_run;
    end
  end
endmodule // chgim_host

// >>> dv/chgim_top_bench.sv
// Self-checking bench for the charger interrupt mask block
`timescale 1ns/1ps
module chgim_top_bench;
  import chgim_pkg::*;
  localparam int BPOS [15] = '{6, 5, 4, 3, 2, 1, 0, 3, 0, 7, 6, 5, 4, 3, 0};
  localparam logic [7:0] KEEP [3] = '{8'hFF, 8'h09, 8'hF9};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_reset = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic adc_one_shot = 1'b1;
  logic [14:0] ev = 15'h0000;
  logic [7:0] reg_rdata_q;
  logic int_n_q;
  logic [31:0] seed = 32'h08aa_53f6;
  logic [7:0] v;
  logic [7:0] r;
  int irq_count;
  int last_width;
  int n;
  int failures = 0;
  int samples_checked = 0;
  always #4 mclk = ~mclk;
  chgim_top uut (.mclk(mclk), .rst_n(rst_n), .reg_reset(reg_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .adc_one_shot(adc_one_shot), .adc_done(ev[0]),
    .die_thermal_regulation(ev[1]), .min_system_regulation(ev[2]), .input_current_regulation(ev[3]),
    .input_voltage_regulation(ev[4]), .charge_timer_expired(ev[5]), .watchdog_expired(ev[6]),
    .charge_status({2'b00, ev[7]}), .input_bus_status({2'b00, ev[8]}), .bus_fault(ev[9]), .bat_fault(ev[10]),
    .sys_fault(ev[11]), .otg_fault(ev[12]), .thermal_shutdown(ev[13]), .temp_zone({2'b00, ev[14]}),
    .int_n_q(int_n_q));
  chgim_host host (.mclk(mclk), .rst_n(rst_n), .int_n_q(int_n_q), .irq_count(irq_count), .last_width(last_width));
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [7:0] mofs(int i);
    return i < 7 ? OFS_CHARGE_STATE_IRQ_BLOCK_A : (i < 9 ? OFS_CHARGE_STATE_IRQ_BLOCK_B : OFS_FAULT_MASK);
  endfunction
  // Level events pulse once, min system regulation and status-like events on both edges
  function automatic int exp_pulses(int i, int m);
    return m ? 0 : ((i == 2 || i == 7 || i == 8 || i == 14) ? 2 : 1);
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask
  task automatic pulse_ev(input int i);
    @(posedge mclk) ev[i] <= 1'b1;
    repeat (45) @(posedge mclk);
    ev[i] <= 1'b0;
    repeat (45) @(posedge mclk);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    for (int j = 0; j < 3; j++) begin
      rd(OFS_CHARGE_STATE_IRQ_BLOCK_A + 8'(j), r);
      chk(r, 8'h00);
    end
    for (int k = 0; k < 8; k++) begin
      for (int j = 0; j < 3; j++) begin
        seed = xs(seed);
        v = (k == 0 || k == 7) ? 8'hFF : seed[7:0];
        wr(OFS_CHARGE_STATE_IRQ_BLOCK_A + 8'(j), v);
        rd(OFS_CHARGE_STATE_IRQ_BLOCK_A + 8'(j), r);
        chk(r, v & KEEP[j]);
      end
    end
    @(posedge mclk) reg_reset <= 1'b1;
    @(posedge mclk) reg_reset <= 1'b0;
    for (int j = 0; j < 3; j++) begin
      rd(OFS_CHARGE_STATE_IRQ_BLOCK_A + 8'(j), r);
      chk(r, 8'h00);
    end
    for (int i = 0; i < 15; i++) begin
      for (int m = 1; m >= 0; m--) begin
        wr(mofs(i), 8'(m) << BPOS[i]);
        rd(mofs(i) - 8'h03, r);
        n = irq_count;
        pulse_ev(i);
        rd(mofs(i) - 8'h03, r);
        chk(r, 8'h01 << BPOS[i]);
        chk(8'(irq_count - n), 8'(exp_pulses(i, m)));
        if (m == 0) chk(8'(last_width), 8'(INT_PULSE_CYC));
      end
    end
    @(posedge mclk) adc_one_shot <= 1'b0;
    n = irq_count;
    pulse_ev(0);
    rd(OFS_CHG_FLAG_A, r);
    chk(r, 8'h00);
    chk(8'(irq_count - n), 8'h00);
    summarize();
  end
endmodule // chgim_top_bench
